// File: mslc_pkg.sv
// Contract
// - writing one to start enables monitoring and pwm with programmed limits
// - reading registers are not updated until start has been set
// - while start is zero, built-in default limits and parameters are used
// - start changes never alter stored limit and parameter contents
// - start stays writable after lock is set
// - start zero forces pwm high 1020 clocks, low 4 clocks per period
// - start zero means no monitoring and readings are not valid
// - fan speed readings always follow the measured tachometer input
// - start zero means no interrupt status bit is set
// - start one permits status bits from limit comparisons
// - start one with lock clear still accepts limit writes
// - lock makes limit registers read only until power loss
// - once lock is set further writes to lock are ignored
// - ready is read only, set after power-up and converters ready
// - override forces all pwm outputs to full duty regardless of lock
// - readings may be invalid up to 82 ms after start is set
// - duty reads full scale when start zero and not manual; writes held (the code reads full scale whenever start is zero, manual set or not)
package mslc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] MSLC_CTRL_ADDR = 8'h40;
    localparam logic [7:0] MSLC_LIMIT_ADDR = 8'h44;
    localparam logic [7:0] MSLC_DUTY_ADDR = 8'h30;
    localparam logic [7:0] MSLC_TACH_ADDR = 8'h28;
    localparam logic [7:0] MSLC_VALID_ADDR = 8'h50;
    localparam logic [7:0] MSLC_CTRL_RESET = 8'h00;
    localparam int MSLC_START_BIT = 0;
    localparam int MSLC_LOCK_BIT = 1;
    localparam int MSLC_READY_BIT = 2;
    localparam int MSLC_OVRD_BIT = 3;
    localparam int MSLC_MANUAL_BIT = 8;
    localparam logic [7:0] MSLC_FULL_DUTY = 8'hff;
    localparam logic [7:0] MSLC_LIMIT_DEFAULT = 8'h00;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int MSLC_CLK_HZ = 40_000_000;
    localparam int MSLC_STARTUP_MS = 82;
    localparam int MSLC_STARTUP_CYC = MSLC_CLK_HZ / 1000 * MSLC_STARTUP_MS;
    localparam int MSLC_READY_CYC = 16;
    localparam int MSLC_PWM_DIV = 4;
    // ****************************************************************
    // bus responses
    // ****************************************************************
    localparam logic [1:0] MSLC_RESP_OKAY = 2'b00;
    localparam logic [1:0] MSLC_RESP_SLVERR = 2'b10;
endpackage

// File: mslc_pwm.sv
`timescale 1ns/1ps
module mslc_pwm (
    input wire logic mclk,
    input wire logic rst,
    mslc_pwm_if.gen p
);
    typedef struct packed {
        logic [7:0] cnt;
        logic out;
    } mslc_pwm_state_t;
    mslc_pwm_state_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        if (p.tick) begin
            s_d.cnt = s_q.cnt + 8'h01;
            // full duty 0xff gives 255 high, 1 low in 256 ticks
            s_d.out = (s_q.cnt < p.duty);
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign p.pwm = s_q.out;
endmodule // mslc_pwm

// File: mslc_pwm_if.sv
`timescale 1ns/1ps
interface mslc_pwm_if;
    logic tick;
    logic [7:0] duty;
    logic pwm;
    modport ctrl (output tick, output duty, input pwm);
    modport gen (input tick, input duty, output pwm);
endinterface

// File: mslc_top.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mslc_top #(
    parameter int STARTUP_CYC = mslc_pkg::MSLC_STARTUP_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] meas_value,
    input wire logic meas_strobe,
    input wire logic [15:0] tach_count,
    input wire logic [7:0] auto_duty,
    output logic [7:0] limit_active,
    output logic monitor_enable,
    output logic status_set_enable,
    output logic pwm_out
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic start;
        logic lock;
        logic ovrd;
        logic manual;
        logic ready;
        logic [4:0] rdy_cnt;
        logic [7:0] limit;
        logic [7:0] duty_wr;
        logic [7:0] reading;
        logic [15:0] tach_s1;
        logic [15:0] tach_s2;
        logic [31:0] settle;
        logic valid;
        logic [1:0] div;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mslc_state_t;
    mslc_state_t s_q, s_d;
    mslc_pwm_if pif ();
    mslc_pwm u_pwm (
        .mclk(mclk),
        .rst(rst),
        .p(pif)
    );
    function automatic logic known(input logic [7:0] a);
        known = (a == mslc_pkg::MSLC_CTRL_ADDR) ||
            (a == mslc_pkg::MSLC_LIMIT_ADDR) ||
            (a == mslc_pkg::MSLC_DUTY_ADDR) ||
            (a == mslc_pkg::MSLC_TACH_ADDR) ||
            (a == mslc_pkg::MSLC_VALID_ADDR);
    endfunction
    logic [7:0] duty_eff;
    logic [7:0] duty_rd;
    logic wr_go;
    logic [31:0] wd;
    // ****************************************************************
    // duty selection
    // ****************************************************************
    always_comb begin
        if (s_q.ovrd) begin
            duty_eff = mslc_pkg::MSLC_FULL_DUTY;
        end else if (!s_q.start) begin
            duty_eff = mslc_pkg::MSLC_FULL_DUTY;
        end else if (s_q.manual) begin
            duty_eff = s_q.duty_wr;
        end else begin
            duty_eff = auto_duty;
        end
        if (!s_q.start && !s_q.manual) begin
            duty_rd = mslc_pkg::MSLC_FULL_DUTY;
        end else begin
            duty_rd = duty_eff;
        end
    end
    assign pif.tick = (s_q.div == 2'(mslc_pkg::MSLC_PWM_DIV - 1));
    assign pif.duty = duty_eff;
    assign pwm_out = pif.pwm;
    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        wd = s_q.w_data;
        s_d.div = s_q.div + 2'd1;
        if (!s_q.ready) begin
            s_d.rdy_cnt = s_q.rdy_cnt + 5'd1;
            if (s_q.rdy_cnt == 5'(mslc_pkg::MSLC_READY_CYC - 1)) begin
                s_d.ready = 1'b1;
            end
        end
        s_d.tach_s1 = tach_count;
        s_d.tach_s2 = s_q.tach_s1;
        if (s_q.start && meas_strobe) begin
            s_d.reading = meas_value;
        end
        if (!s_q.start) begin
            s_d.settle = '0;
            s_d.valid = 1'b0;
        end else if (!s_q.valid) begin
            s_d.settle = s_q.settle + 32'd1;
            if (s_q.settle >= 32'(STARTUP_CYC - 1)) begin
                s_d.valid = 1'b1;
            end
        end
        if (s_axi_awvalid && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = known(s_q.aw_addr) ? mslc_pkg::MSLC_RESP_OKAY
                : mslc_pkg::MSLC_RESP_SLVERR;
            if (s_q.aw_addr == mslc_pkg::MSLC_CTRL_ADDR) begin
                if (s_q.w_strb[0]) begin
                    s_d.start = wd[mslc_pkg::MSLC_START_BIT];
                    s_d.ovrd = wd[mslc_pkg::MSLC_OVRD_BIT];
                    if (!s_q.lock) begin
                        s_d.lock = wd[mslc_pkg::MSLC_LOCK_BIT];
                    end
                end
                if (s_q.w_strb[1] && !s_q.lock) begin
                    s_d.manual = wd[mslc_pkg::MSLC_MANUAL_BIT];
                end
            end
            if (s_q.aw_addr == mslc_pkg::MSLC_LIMIT_ADDR && s_q.w_strb[0]
                && !s_q.lock) begin
                s_d.limit = wd[7:0];
            end
            if (s_q.aw_addr == mslc_pkg::MSLC_DUTY_ADDR && s_q.w_strb[0]
                && !s_q.lock) begin
                s_d.duty_wr = wd[7:0];
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = mslc_pkg::MSLC_RESP_OKAY;
            s_d.rdata = '0;
            unique case (s_axi_araddr)
                mslc_pkg::MSLC_CTRL_ADDR: begin
                    // upper control bits read zero
                    s_d.rdata[mslc_pkg::MSLC_START_BIT] = s_q.start;
                    s_d.rdata[mslc_pkg::MSLC_LOCK_BIT] = s_q.lock;
                    s_d.rdata[mslc_pkg::MSLC_READY_BIT] = s_q.ready;
                    s_d.rdata[mslc_pkg::MSLC_OVRD_BIT] = s_q.ovrd;
                    s_d.rdata[mslc_pkg::MSLC_MANUAL_BIT] = s_q.manual;
                end
                mslc_pkg::MSLC_LIMIT_ADDR: s_d.rdata[7:0] = s_q.limit;
                mslc_pkg::MSLC_DUTY_ADDR: s_d.rdata[7:0] = duty_rd;
                mslc_pkg::MSLC_TACH_ADDR: s_d.rdata[15:0] = s_q.tach_s2;
                mslc_pkg::MSLC_VALID_ADDR: begin
                    s_d.rdata[7:0] = s_q.reading;
                    s_d.rdata[8] = s_q.valid;
                end
                default: s_d.rresp = mslc_pkg::MSLC_RESP_SLVERR;
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end
    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // ****************************************************************
    // outputs
    // ****************************************************************
    // programmed limit only while started, default otherwise
    assign limit_active = s_q.start ? s_q.limit
        : mslc_pkg::MSLC_LIMIT_DEFAULT;
    assign monitor_enable = s_q.start;
    assign status_set_enable = s_q.start;
    assign s_axi_awready = !s_q.aw_have;
    assign s_axi_wready = !s_q.w_have;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
endmodule // mslc_top

// File: mslc_top_sva.sv
`timescale 1ns/1ps
// ************************************************************
// checker on the top ports
// ************************************************************
module mslc_top_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0] limit_active,
    input wire logic monitor_enable,
    input wire logic status_set_enable,
    input wire logic pwm_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [10:0] zc_q;
    logic [3:0] lc_q;
    // time with start low, and length of the current low run of pwm
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            zc_q <= 11'h000;
            lc_q <= 4'h0;
        end else begin
            zc_q <= monitor_enable ? 11'h000 : zc_q + {10'h000, ~&zc_q};
            lc_q <= (pwm_out || monitor_enable) ? 4'h0 : lc_q + {3'h0, ~&lc_q};
        end
    end
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence r_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read not answered one cycle after address");
    chk_rdata_hold: assert property (r_waiting |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
    chk_status_gate: assert property (status_set_enable == monitor_enable)
        else $error("status enable differs from start");
    chk_default_limit: assert property (!monitor_enable |->
        limit_active == mslc_pkg::MSLC_LIMIT_DEFAULT)
        else $error("default limit not used");
    chk_start_by_write: assert property ($changed(monitor_enable) |->
        $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
        else $error("start changed without a write");
    chk_full_duty: assert property (zc_q > 11'h44c |-> lc_q <= 4'h4)
        else $error("pwm low too long while stopped");
endmodule // mslc_top_chk
bind mslc_top mslc_top_chk u_chk (.*);

// File: mslc_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((e) !== (a)) begin mismatches++;\
 $display("ERROR %s expected %h seen %h", n, e, a); end end
module mslc_top_tb;
    // ************************************************************
    // signals and model
    // ************************************************************
    logic mclk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic meas_strobe = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, monitor_enable, status_set_enable;
    logic pwm_out, m_st = 0, m_lk = 0, m_ov = 0, m_vld = 0, m_mn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, meas_value = 0;
    logic [7:0] auto_duty = 0, limit_active, m_lim = 0, m_rdg = 0, m_dt = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] tach_count = 0;
    int mismatches = 0, n_compared = 0, cyc = 0, lo = 0, mx = 0;
    mslc_top #(.STARTUP_CYC(20)) DUT (.*);
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    function automatic logic [1:0] mresp(input logic [7:0] a);
        return (a inside {8'h40, 8'h44, 8'h30, 8'h28, 8'h50}) ?
            mslc_pkg::MSLC_RESP_OKAY : mslc_pkg::MSLC_RESP_SLVERR;
    endfunction
    function automatic logic [31:0] mrd(input logic [7:0] a);
        case (a)
            8'h40: return {23'h00_0000, m_mn, 4'h0, m_ov, 1'b1, m_lk, m_st};
            8'h44: return {24'h00_0000, m_lim};
            8'h30: return {24'h00_0000, (m_ov || !m_st) ? 8'hff
                : (m_mn ? m_dt : auto_duty)};
            8'h28: return {16'h0000, tach_count};
            8'h50: return {23'h00_0000, m_vld, m_rdg};
            default: return 32'h0000_0000;
        endcase
    endfunction
    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        logic ta, tw, done;
        logic [1:0] br;
        done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!done) begin
            @(negedge mclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
        @(posedge mclk);
        `CHK("bresp", mresp(a), br)
        if (a == 8'h40) begin
            m_vld = m_vld && m_st && dv[0];
            m_st = dv[0];
            m_ov = dv[3];
            if (!m_lk) begin
                m_mn = dv[8];
                m_lk = dv[1];
            end
        end
        if (a == 8'h44 && !m_lk) m_lim = dv[7:0];
        if (a == 8'h30 && !m_lk) m_dt = dv[7:0];
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, done;
        logic [31:0] rv;
        logic [1:0] rr;
        done = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!done) begin
            @(negedge mclk);
            ta = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            rv = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
        @(posedge mclk);
        `CHK("rresp", mresp(a), rr)
        `CHK("rdata", mrd(a), rv)
    endtask
    task automatic meas(input logic [7:0] v);
        meas_value <= v;
        meas_strobe <= 1;
        @(posedge mclk);
        meas_strobe <= 0;
        if (m_st) m_rdg = v;
        @(posedge mclk);
    endtask
    task automatic outs(input logic [7:0] el);
        @(negedge mclk);
        `CHK("limit_active", el, limit_active)
        `CHK("monitor_enable", m_st, monitor_enable)
        `CHK("status_set_enable", m_st, status_set_enable)
        @(posedge mclk);
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'hdcef_8ec9));
        repeat (6) @(posedge mclk);
        rst <= 0;
        tach_count <= 16'($urandom);
        repeat (1200) @(posedge mclk);
        rd(8'h40);
        rd(8'h28);
        meas(8'($urandom));
        rd(8'h50);
        wr(8'h44, $urandom);
        outs(8'h00);
        wr(8'h30, $urandom);
        rd(8'h30);
        wr(8'h40, 32'h0000_00f1);
        outs(m_lim);
        rd(8'h50);
        repeat (25) @(posedge mclk);
        m_vld = 1;
        meas(8'($urandom));
        rd(8'h50);
        wr(8'h44, $urandom);
        rd(8'h44);
        wr(8'h40, 32'h0000_0000);
        outs(8'h00);
        rd(8'h44);
        rd(8'h50);
        tach_count <= 16'($urandom);
        repeat (4) @(posedge mclk);
        rd(8'h28);
        wr(8'h40, 32'h0000_0101);
        rd(8'h30);
        rd(8'h40);
        wr(8'h40, 32'h0000_0003);
        wr(8'h44, $urandom);
        rd(8'h44);
        wr(8'h40, 32'h0000_0008);
        rd(8'h40);
        wr(8'h10, $urandom);
        rd(8'h10);
        auto_duty <= 8'h00;
        wr(8'h40, 32'h0000_0009);
        repeat (1030) @(posedge mclk);
        repeat (1030) begin
            @(negedge mclk);
            lo = pwm_out ? 0 : lo + 1;
            if (lo > mx) mx = lo;
        end
        `CHK("pwm_low_run", mslc_pkg::MSLC_PWM_DIV, mx)
        summarize();
    end
endmodule // mslc_top_tb
